//--- idsel_pkg.sv
// constants for the identification and sector-protect host controller
// assumes the flash part sits on plain parallel pins driven by this host
package idsel_pkg;
  localparam int ADDR_W          = 20;
  localparam int SECT_W          = 8;
  localparam int SECT_LSB        = 12;
  localparam int ADDR_NINE_BIT   = 9;
  localparam int ADDR_SIX_BIT    = 6;
  localparam logic [1:0] SEL_MAKER  = 2'h0;
  localparam logic [1:0] SEL_DEVICE = 2'h1;
  localparam logic [1:0] SEL_PROT   = 2'h2;
  localparam logic [7:0] PROT_SET   = 8'h01;
  localparam logic [7:0] PROT_CLEAR = 8'h00;
  // bus timing in ns, setup before strobe and strobe width
  localparam int T_SETUP_NS  = 50;
  localparam int T_STROBE_NS = 90;
  localparam int CLK_NS      = 8;
  localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 8;
  typedef enum logic [1:0] {
    OP_READ_ID  = 2'h0,
    OP_WRITE    = 2'h1,
    OP_READ_PRT = 2'h2,
    OP_READ     = 2'h3
  } op_t;
endpackage

//--- cycle_timer.sv
// one-shot down counter producing a done pulse after a programmed count
// assumes load is a single-cycle pulse
`timescale 1ns/1ns
module cycle_timer #(
  parameter int CNT_W = 8
) (
  input  wire logic             clock_in,   // system clock
  input  wire logic             resetn_in,  // async reset, low
  input  wire logic             load_in,    // start pulse
  input  wire logic [CNT_W-1:0] count_in,   // cycles to wait
  output logic                  done_out    // one-cycle pulse at expiry
);
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             run_r, run_nxt;
  logic             done_r, done_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (load_in) begin
      cnt_nxt = count_in;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r <= CNT_W'(1)) begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      run_r  <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_out = done_r;
endmodule

//--- idsel_host.sv
// host controller driving a boot-sector flash through its pins for
// identification reads, sector protect status and high-voltage control
// assumes external switches apply the high voltage when the enables are high
//
// Functional notes
// - host raises high_id_voltage on addr_line_nine for identification mode
// - addr six low; A1/A0 pick maker 00, device 01, protect 10
// - sector_select_address goes on top address lines for status reads
// - all lines settle before a read with chip, output enable low
// - command-interface identification needs no high voltage
// - primary protect method uses reset-pin high voltage and bus cycles
// - protect every unprotected sector before the first unprotect write
// - alternate method needs high voltage on addr nine and output enable
// - sector decode uses A19 down to A-1 byte mode, A0 word mode
`timescale 1ns/1ns
module idsel_host #(
  parameter int ADDR_W = idsel_pkg::ADDR_W,
  parameter int SECT_W = idsel_pkg::SECT_W
) (
  input  wire logic              clock_in,          // 125 MHz clock
  input  wire logic              resetn_in,         // async reset, low
  input  wire logic              req_valid_in,      // start an operation
  input  wire logic [1:0]        req_op_in,         // op_t code
  input  wire logic [SECT_W-1:0] req_sector_in,     // sector for status reads
  input  wire logic [ADDR_W-1:0] req_addr_in,       // address for plain bus ops
  input  wire logic [7:0]        req_wdata_in,      // data for write cycles
  input  wire logic [1:0]        req_id_sel_in,     // maker or device code
  input  wire logic              hv_reset_en_in,    // request reset-pin high voltage
  input  wire logic              hv_alt_en_in,      // request alternate method voltages
  output logic                   req_ready_out,     // idle, may accept request
  output logic                   rsp_valid_out,     // read data valid pulse
  output logic [7:0]             rsp_data_out,      // byte read back
  output logic                   rsp_protected_out, // status read said protected
  output logic [ADDR_W-1:0]      flash_addr_out,    // address pins
  output logic                   flash_ce_n_out,    // chip enable, low
  output logic                   flash_oe_n_out,    // output enable, low
  output logic                   flash_we_n_out,    // write enable, low
  input  wire logic [7:0]        low_data_byte_in,  // data pins read
  output logic [7:0]             low_data_byte_out, // data pins driven
  output logic                   low_data_byte_oe_out, // data driver enable
  output logic                   hv_addr_nine_out,  // high_id_voltage on addr_line_nine
  output logic                   hv_oe_pin_out,     // high_id_voltage on output enable pin
  output logic                   hv_reset_pin_out   // high_id_voltage on reset pin
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_STROBE = 3'h2,
    ST_DONE   = 3'h3
  } state_t;

  state_t                   state_r, state_nxt;
  idsel_pkg::op_t           op_r, op_nxt;
  logic [ADDR_W-1:0]        addr_r, addr_nxt;
  logic [7:0]               wdata_r, wdata_nxt;
  logic [7:0]               rdata_r, rdata_nxt;
  logic                     rvalid_r, rvalid_nxt;
  logic                     prot_r, prot_nxt;
  logic                     ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt;
  logic                     doe_r, doe_nxt;
  logic                     hv9_r, hv9_nxt, hvoe_r, hvoe_nxt, hvrst_r, hvrst_nxt;
  logic                     tmr_load;
  logic [idsel_pkg::CNT_W-1:0] tmr_count;
  logic                     tmr_done;

  // id address: sector on top lines, addr six low, select on A1/A0
  function automatic logic [ADDR_W-1:0] id_addr(input logic [SECT_W-1:0] sect,
                                                input logic [1:0] sel);
    logic [ADDR_W-1:0] a;
    a = '0;
    a[idsel_pkg::SECT_LSB +: SECT_W] = sect;
    a[idsel_pkg::ADDR_SIX_BIT]       = 1'b0;
    a[1:0]                           = sel;
    return a;
  endfunction

  cycle_timer #(.CNT_W(idsel_pkg::CNT_W)) u_timer (
    .clock_in (clock_in),
    .resetn_in(resetn_in),
    .load_in  (tmr_load),
    .count_in (tmr_count),
    .done_out (tmr_done)
  );

  always_comb begin
    state_nxt  = state_r;
    op_nxt     = op_r;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    prot_nxt   = prot_r;
    ce_n_nxt   = ce_n_r;
    oe_n_nxt   = oe_n_r;
    we_n_nxt   = we_n_r;
    doe_nxt    = doe_r;
    tmr_load   = 1'b0;
    tmr_count  = '0;
    // voltages only change between cycles so the part never sees a glitch mid-strobe
    hv9_nxt    = hv9_r;
    hvoe_nxt   = hvoe_r;
    hvrst_nxt  = hvrst_r;
    case (state_r)
      ST_IDLE: begin
        hvrst_nxt = hv_reset_en_in;
        hvoe_nxt  = hv_alt_en_in;
        hv9_nxt   = hv_alt_en_in;
        if (req_valid_in) begin
          op_nxt    = idsel_pkg::op_t'(req_op_in);
          wdata_nxt = req_wdata_in;
          ce_n_nxt  = 1'b0;
          case (idsel_pkg::op_t'(req_op_in))
            idsel_pkg::OP_READ_ID: begin
              addr_nxt = id_addr('0, req_id_sel_in);
              hv9_nxt  = 1'b1;
            end
            idsel_pkg::OP_READ_PRT: begin
              addr_nxt = id_addr(req_sector_in, idsel_pkg::SEL_PROT);
              hv9_nxt  = 1'b1;
            end
            idsel_pkg::OP_WRITE: begin
              // command writes reach autoselect without high voltage
              addr_nxt = req_addr_in;
              doe_nxt  = 1'b1;
            end
            default: begin
              addr_nxt = req_addr_in;
            end
          endcase
          tmr_load  = 1'b1;
          tmr_count = idsel_pkg::CNT_W'(idsel_pkg::SETUP_CYC);
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          // strobe only after every line has settled
          if (op_r == idsel_pkg::OP_WRITE) begin
            we_n_nxt = 1'b0;
          end else begin
            oe_n_nxt = 1'b0;
          end
          tmr_load  = 1'b1;
          tmr_count = idsel_pkg::CNT_W'(idsel_pkg::STROBE_CYC);
          state_nxt = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (tmr_done) begin
          if (op_r != idsel_pkg::OP_WRITE) begin
            rdata_nxt  = low_data_byte_in;
            rvalid_nxt = 1'b1;
            prot_nxt   = (op_r == idsel_pkg::OP_READ_PRT) &&
                         (low_data_byte_in == idsel_pkg::PROT_SET);
          end
          oe_n_nxt  = 1'b1;
          we_n_nxt  = 1'b1;
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        ce_n_nxt  = 1'b1;
        doe_nxt   = 1'b0;
        hv9_nxt   = hv_alt_en_in;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r  <= ST_IDLE;
      op_r     <= idsel_pkg::OP_READ_ID;
      addr_r   <= '0;
      wdata_r  <= 8'h00;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
      prot_r   <= 1'b0;
      ce_n_r   <= 1'b1;
      oe_n_r   <= 1'b1;
      we_n_r   <= 1'b1;
      doe_r    <= 1'b0;
      hv9_r    <= 1'b0;
      hvoe_r   <= 1'b0;
      hvrst_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      op_r     <= op_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      prot_r   <= prot_nxt;
      ce_n_r   <= ce_n_nxt;
      oe_n_r   <= oe_n_nxt;
      we_n_r   <= we_n_nxt;
      doe_r    <= doe_nxt;
      hv9_r    <= hv9_nxt;
      hvoe_r   <= hvoe_nxt;
      hvrst_r  <= hvrst_nxt;
    end
  end

  assign req_ready_out        = (state_r == ST_IDLE);
  assign rsp_valid_out        = rvalid_r;
  assign rsp_data_out         = rdata_r;
  assign rsp_protected_out    = prot_r;
  assign flash_addr_out       = addr_r;
  assign flash_ce_n_out       = ce_n_r;
  assign flash_oe_n_out       = oe_n_r;
  assign flash_we_n_out       = we_n_r;
  assign low_data_byte_out    = wdata_r;
  assign low_data_byte_oe_out = doe_r;
  assign hv_addr_nine_out     = hv9_r;
  assign hv_oe_pin_out        = hvoe_r;
  assign hv_reset_pin_out     = hvrst_r;
endmodule

//--- idsel_host_properties.sv
// timing relations on the pins of the identification host
// assumes one clock domain, bound onto every idsel_host
`timescale 1ns/1ns
module idsel_host_properties #(
  parameter int ADDR_W = 20,
  parameter int SECT_W = 8
) (
  input wire logic              clock_in,          // clock
  input wire logic              resetn_in,         // reset, low
  input wire logic              req_valid_in,      // request
  input wire logic [1:0]        req_op_in,         // op code
  input wire logic [SECT_W-1:0] req_sector_in,     // sector
  input wire logic [1:0]        req_id_sel_in,     // id select
  input wire logic              hv_alt_en_in,      // alt voltages
  input wire logic              hv_reset_en_in,    // reset voltage
  input wire logic              req_ready_out,     // idle
  input wire logic              rsp_valid_out,     // answer
  input wire logic [ADDR_W-1:0] flash_addr_out,    // address pins
  input wire logic              flash_ce_n_out,    // chip enable
  input wire logic              flash_oe_n_out,    // output enable
  input wire logic              flash_we_n_out,    // write enable
  input wire logic              low_data_byte_oe_out, // data drive
  input wire logic              hv_addr_nine_out,  // addr nine hv
  input wire logic              hv_reset_pin_out   // reset pin hv
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  wire take = req_valid_in && req_ready_out;
  idle_deselect_a: assert property (req_ready_out |-> flash_ce_n_out)
    else $error("chip selected while idle");
  take_select_a: assert property (take |=> !flash_ce_n_out)
    else $error("no chip select after take");
  id_voltage_a: assert property (take && req_op_in == 2'h0 |=> hv_addr_nine_out)
    else $error("id read without addr nine voltage");
  id_address_a: assert property (take && req_op_in == 2'h0 |=>
    !flash_addr_out[6] && flash_addr_out[1:0] == $past(req_id_sel_in)) else $error("id address wrong");
  status_addr_a: assert property (take && req_op_in == 2'h2 |=>
    flash_addr_out[19:12] == $past(req_sector_in) && flash_addr_out[1:0] == 2'h2) else $error("status address wrong");
  read_strobes_a: assert property (!flash_oe_n_out |-> flash_we_n_out && !flash_ce_n_out)
    else $error("read strobe without proper enables");
  no_contention_a: assert property (low_data_byte_oe_out |-> flash_oe_n_out)
    else $error("data driven during read");
  read_answer_a: assert property (take && req_op_in != 2'h1 |-> ##[10:40] rsp_valid_out)
    else $error("read answer missing");
  plain_no_hv_a: assert property (take && req_op_in == 2'h3 && !hv_alt_en_in |=> !hv_addr_nine_out)
    else $error("plain read with high voltage");
  reset_hv_a: assert property ($rose(hv_reset_pin_out) |-> $past(hv_reset_en_in))
    else $error("reset pin voltage unrequested");
endmodule
bind idsel_host idsel_host_properties #(.ADDR_W(ADDR_W), .SECT_W(SECT_W)) u_props (.*);

//--- flash_model.sv
// behavioural flash: id codes, sector flags, one byte per sector
// assumes the host strobes are active low and data is byte wide
`timescale 1ns/1ns
module flash_model #(
  parameter logic [7:0] MAKER = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVID = 8'hA7  // arbitrary value
) (
  input  wire logic [19:0] addr_in,   // address pins
  input  wire logic        ce_n_in,   // chip enable
  input  wire logic        oe_n_in,   // output enable
  input  wire logic        we_n_in,   // write enable
  input  wire logic [7:0]  wdata_in,  // data from host
  input  wire logic        hv9_in,    // addr nine detect
  input  wire logic        hvoe_in,   // oe pin detect
  input  wire logic        hvrst_in,  // reset pin detect
  output logic      [7:0]  dq_out     // data to host
);
  // flags never reset: they stand for nonvolatile cells
  logic [255:0] prot = '0;
  logic [7:0]   mem [256];
  logic [7:0]   val;
  logic [7:0]   last = 8'h00;
  wire  [7:0]   s = addr_in[19:12];
  wire  drive = !ce_n_in && !oe_n_in;
  initial foreach (mem[i]) mem[i] = 8'h00;
  always_comb val = !hv9_in ? mem[s] : addr_in[1:0] == 2'h0 ? MAKER :
    addr_in[1:0] == 2'h1 ? DEVID : {7'h00, prot[s] && !hvrst_in};
  always @(val or drive) if (drive) last = val;
  // released bus shows the inverse so a stale byte never passes
  assign dq_out = drive ? val : ~last;
  always @(posedge we_n_in) begin
    if (!ce_n_in && hv9_in && hvoe_in) prot[s] <= wdata_in[0];
    else if (!ce_n_in && (!prot[s] || hvrst_in)) mem[s] <= wdata_in;
  end
endmodule

//--- tb_top.sv
// self-checking bench: host controller against the flash model
// assumes 125 MHz clock, reset held 8 cycles
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] MK = 8'h5A;
  localparam logic [7:0] DV = 8'hA7;
  logic clock_in, resetn_in, req_valid_in, hv_reset_en_in, hv_alt_en_in;
  logic [1:0] req_op_in, req_id_sel_in;
  logic [7:0] req_sector_in, req_wdata_in, dq, wd, rd, s, d0;
  logic [19:0] req_addr_in, fa;
  logic ready, rv, prt, ce, oe, we, doe, h9, hoe, hr;
  logic [15:0] lf = 16'h5766;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_rv = 0;
  idsel_host u_dut (.clock_in(clock_in), .resetn_in(resetn_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_sector_in(req_sector_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_id_sel_in(req_id_sel_in), .hv_reset_en_in(hv_reset_en_in),
    .hv_alt_en_in(hv_alt_en_in), .req_ready_out(ready), .rsp_valid_out(rv), .rsp_data_out(rd),
    .rsp_protected_out(prt), .flash_addr_out(fa), .flash_ce_n_out(ce), .flash_oe_n_out(oe),
    .flash_we_n_out(we), .low_data_byte_in(dq), .low_data_byte_out(wd), .low_data_byte_oe_out(doe),
    .hv_addr_nine_out(h9), .hv_oe_pin_out(hoe), .hv_reset_pin_out(hr));
  flash_model #(.MAKER(MK), .DEVID(DV)) u_flash (.addr_in(fa), .ce_n_in(ce), .oe_n_in(oe),
    .we_n_in(we), .wdata_in(wd), .hv9_in(h9), .hvoe_in(hoe), .hvrst_in(hr), .dq_out(dq));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  function automatic logic [7:0] exp_id(input logic [1:0] sl);
    return sl == idsel_pkg::SEL_MAKER ? MK : DV;
  endfunction
  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge clock_in);
      #1;
      n++;
    end
  endtask
  task automatic op(input logic [1:0] o, input logic [7:0] sc, input logic [7:0] d, input logic [1:0] sl);
    wait_idle();
    lf = nx(lf);
    req_op_in = o;
    req_sector_in = sc;
    req_addr_in = {sc, lf[11:0]};
    req_wdata_in = d;
    req_id_sel_in = sl;
    req_valid_in = 1'b1;
    @(posedge clock_in);
    #1;
    req_valid_in = 1'b0;
    wait_idle();
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (rv === 1'b1) n_rv++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    {resetn_in, req_valid_in, hv_reset_en_in, hv_alt_en_in, req_op_in, req_id_sel_in} = '0;
    {req_sector_in, req_wdata_in, req_addr_in} = '0;
    repeat (8) @(posedge clock_in);
    #1;
    resetn_in = 1'b1;
    chk({2'h0, ce, oe, we, h9, hoe, hr}, 8'h38, "reset pin levels");
    for (int i = 0; i < 2; i++) begin
      op(2'h0, 8'h00, 8'h00, i[1:0]);
      chk(rd, exp_id(i[1:0]), "id code");
    end
    lf = nx(lf);
    s = lf[15:8];
    op(2'h2, s, 8'h00, 2'h0);
    chk(rd, idsel_pkg::PROT_CLEAR, "fresh sector status");
    chk({7'h00, prt}, 8'h00, "fresh sector flag");
    d0 = lf[7:0] ^ 8'h3C;
    op(2'h1, s, d0, 2'h0);
    hv_alt_en_in = 1'b1;
    op(2'h1, s, idsel_pkg::PROT_SET, 2'h0);
    hv_alt_en_in = 1'b0;
    op(2'h2, s, 8'h00, 2'h0);
    chk(rd, idsel_pkg::PROT_SET, "status after protect");
    chk({7'h00, prt}, 8'h01, "protected flag");
    op(2'h1, s, ~d0, 2'h0);
    op(2'h3, s, 8'h00, 2'h0);
    chk(rd, d0, "protected sector changed");
    hv_reset_en_in = 1'b1;
    repeat (3) @(posedge clock_in);
    #1;
    op(2'h1, s, ~d0, 2'h0);
    op(2'h3, s, 8'h00, 2'h0);
    chk(rd, ~d0, "temporary unprotect write");
    hv_reset_en_in = 1'b0;
    repeat (3) @(posedge clock_in);
    #1;
    op(2'h2, s, 8'h00, 2'h0);
    chk(rd, idsel_pkg::PROT_SET, "protection restored");
    hv_alt_en_in = 1'b1;
    // every sector protected before the first unprotect write
    for (int j = 0; j < 256; j++) op(2'h1, j[7:0], idsel_pkg::PROT_SET, 2'h0);
    op(2'h1, s, idsel_pkg::PROT_CLEAR, 2'h0);
    hv_alt_en_in = 1'b0;
    op(2'h2, s ^ 8'h01, 8'h00, 2'h0);
    chk(rd, idsel_pkg::PROT_SET, "other sector still protected");
    op(2'h1, s, d0, 2'h0);
    op(2'h3, s, 8'h00, 2'h0);
    chk(rd, d0, "write after clear");
    chk(n_rv[7:0], 8'h09, "answer pulse count");
    complete_run();
  end
endmodule
